/* hdl/sfdl_cfg.svh */
`ifndef SFDL_CFG_SVH
`define SFDL_CFG_SVH

// Channel layout
`define SFDL_NUM_CH          8
`define SFDL_NUM_DUAL        4
`define SFDL_FIRST_DUAL      4
`define SFDL_HV_CH           0

// Field widths
`define SFDL_TH_W            8
`define SFDL_HYST_W          5
`define SFDL_GLITCH_W        7
`define SFDL_CFG_W           5
`define SFDL_CNT_W           11
`define SFDL_ADDR_W          7
`define SFDL_DATA_W          8

// Threshold code ceiling, full-scale code over the range span
`define SFDL_TH_MAX          8'hFF

// Configuration register fields
`define SFDL_CFG_MODE_LSB    0
`define SFDL_CFG_RANGE_LSB   2
`define SFDL_CFG_DIGITAL_BIT 4

// Range select codes: bottom/span 0.573/0.802, 1.25/1.75, 2.5/3.5, 6.0/8.4
`define SFDL_RANGE_LOW       2'h0
`define SFDL_RANGE_MID       2'h1
`define SFDL_RANGE_HIGH      2'h2
`define SFDL_RANGE_TOP       2'h3

// Glitch filter timing
`define SFDL_CLK_HZ          20000000
`define SFDL_US_PER_S        1000000
`define SFDL_GLITCH_MAX_US   100
`define SFDL_CYC_PER_US      (`SFDL_CLK_HZ / `SFDL_US_PER_S)

// Register map: per-channel block of eight slots
`define SFDL_CH_STRIDE_LSB   3
`define SFDL_REG_UV_TH       3'h0
`define SFDL_REG_OV_TH       3'h1
`define SFDL_REG_CFG         3'h2
`define SFDL_REG_HYST        3'h3
`define SFDL_REG_GLITCH      3'h4
`define SFDL_GLOBAL_BIT      6
`define SFDL_ADDR_STATUS     7'h40
`define SFDL_ADDR_MASK       7'h41
`define SFDL_ADDR_LIVE       7'h42
`define SFDL_ADDR_LOGIC      7'h43

// Reset values
`define SFDL_RST_ZERO        8'h00

`endif

/* hdl/sfdl_pkg.sv */
`include "sfdl_cfg.svh"

package sfdl_pkg;

    // Detection mode of a channel
    typedef enum logic [1:0] {
        SFDL_MODE_OFF = 2'h0,
        SFDL_MODE_UV  = 2'h1,
        SFDL_MODE_OV  = 2'h2,
        SFDL_MODE_WIN = 2'h3
    } sfdl_mode_t;

    // Whole state of the detector back end
    typedef struct packed {
        logic [`SFDL_NUM_CH-1:0][`SFDL_TH_W-1:0]     uv_th;
        logic [`SFDL_NUM_CH-1:0][`SFDL_TH_W-1:0]     ov_th;
        logic [`SFDL_NUM_CH-1:0][`SFDL_CFG_W-1:0]    cfg;
        logic [`SFDL_NUM_CH-1:0][`SFDL_HYST_W-1:0]   hyst;
        logic [`SFDL_NUM_CH-1:0][`SFDL_GLITCH_W-1:0] glitch;
        logic [`SFDL_NUM_CH-1:0][`SFDL_TH_W-1:0]     uv_code;
        logic [`SFDL_NUM_CH-1:0][`SFDL_TH_W-1:0]     ov_code;
        logic [`SFDL_NUM_CH-1:0]                     uv_s1;
        logic [`SFDL_NUM_CH-1:0]                     uv_s2;
        logic [`SFDL_NUM_CH-1:0]                     ov_s1;
        logic [`SFDL_NUM_CH-1:0]                     ov_s2;
        logic [`SFDL_NUM_DUAL-1:0]                   lg_s1;
        logic [`SFDL_NUM_DUAL-1:0]                   lg_s2;
        logic [`SFDL_NUM_CH-1:0]                     last;
        logic [`SFDL_NUM_CH-1:0]                     filt;
        logic [`SFDL_NUM_CH-1:0][`SFDL_CNT_W-1:0]    cnt;
        logic [`SFDL_NUM_CH-1:0]                     sticky;
        logic [`SFDL_NUM_CH-1:0]                     mask;
        logic [`SFDL_DATA_W-1:0]                     rdata;
    } sfdl_state_t;

endpackage

/* hdl/sfdl_core.sv */
`timescale 1ns/1ps
`include "sfdl_cfg.svh"

module sfdl_core (
    input  wire logic                                 i_core_clk,
    input  wire logic                                 i_rst,
    // Register port
    input  wire logic [`SFDL_ADDR_W-1:0]              i_addr,
    input  wire logic [`SFDL_DATA_W-1:0]              i_wdata,
    input  wire logic                                 i_wr,
    input  wire logic                                 i_rd,
    output logic      [`SFDL_DATA_W-1:0]              o_rdata,
    // Analog comparator results and dual-function logic pins, asynchronous to this clock
    input  wire logic [`SFDL_NUM_CH-1:0]              i_uv_cmp,
    input  wire logic [`SFDL_NUM_CH-1:0]              i_ov_cmp,
    input  wire logic [`SFDL_NUM_DUAL-1:0]            i_dual_logic_pin,
    // Codes and range presented to the analog front end
    output logic      [`SFDL_NUM_CH*`SFDL_TH_W-1:0]   o_uv_code,
    output logic      [`SFDL_NUM_CH*`SFDL_TH_W-1:0]   o_ov_code,
    output logic      [`SFDL_NUM_CH*2-1:0]            o_range_sel,
    output logic      [`SFDL_NUM_DUAL-1:0]            o_dual_is_logic,
    // Filtered results
    output logic      [`SFDL_NUM_CH-1:0]              o_fault,
    output logic      [`SFDL_NUM_DUAL-1:0]            o_logic_in,
    output logic                                      o_irq
);

    // Registered and next state
    sfdl_pkg::sfdl_state_t s_q;
    sfdl_pkg::sfdl_state_t s_d;

    // Range legal for a channel kind; illegal requests snap to a legal one
    function automatic logic [1:0] legal_range(input int ch, input logic [1:0] req);
        logic [1:0] r;
        r = req;
        if (ch == `SFDL_HV_CH) begin
            // High-voltage channel offers the two top ranges only
            if (req == `SFDL_RANGE_LOW || req == `SFDL_RANGE_MID) begin
                r = `SFDL_RANGE_HIGH;
            end
        end else if (ch < `SFDL_FIRST_DUAL) begin
            // Positive channels offer the lower three ranges
            if (req == `SFDL_RANGE_TOP) begin
                r = `SFDL_RANGE_HIGH;
            end
        end else begin
            // Dual-function channels have the lowest range only
            r = `SFDL_RANGE_LOW;
        end
        return r;
    endfunction

    // Threshold plus hysteresis, saturating at full scale
    function automatic logic [`SFDL_TH_W-1:0] add_sat(
        input logic [`SFDL_TH_W-1:0]   th,
        input logic [`SFDL_HYST_W-1:0] hy
    );
        logic [`SFDL_TH_W:0] sum;
        sum = {1'b0, th} + {4'h0, hy};
        if (sum[`SFDL_TH_W]) begin
            return `SFDL_TH_MAX;
        end
        return sum[`SFDL_TH_W-1:0];
    endfunction

    // Threshold minus hysteresis, saturating at zero
    function automatic logic [`SFDL_TH_W-1:0] sub_sat(
        input logic [`SFDL_TH_W-1:0]   th,
        input logic [`SFDL_HYST_W-1:0] hy
    );
        logic [`SFDL_TH_W-1:0] hy_w;
        hy_w = {3'h0, hy};
        if (th < hy_w) begin
            return `SFDL_RST_ZERO;
        end
        return th - hy_w;
    endfunction

    // Timeout in clock cycles from the microsecond code, capped at the maximum
    function automatic logic [`SFDL_CNT_W-1:0] timeout_cycles(
        input logic [`SFDL_GLITCH_W-1:0] us
    );
        logic [`SFDL_GLITCH_W-1:0] capped;
        logic [`SFDL_CNT_W-1:0]    cyc;
        capped = us;
        if (us > `SFDL_GLITCH_W'(`SFDL_GLITCH_MAX_US)) begin
            capped = `SFDL_GLITCH_W'(`SFDL_GLITCH_MAX_US);
        end
        cyc = `SFDL_CNT_W'(capped) * `SFDL_CNT_W'(`SFDL_CYC_PER_US);
        return cyc;
    endfunction

    // Channel is a dual-function one set to logic input
    function automatic logic is_logic(input int ch, input logic [`SFDL_CFG_W-1:0] c);
        return (ch >= `SFDL_FIRST_DUAL) && c[`SFDL_CFG_DIGITAL_BIT];
    endfunction

    // Next-state logic: bus, synchronisers, detection, filters, interrupts
    always_comb begin
        logic [`SFDL_NUM_CH-1:0]   raw;
        logic [`SFDL_NUM_CH-1:0]   rise;
        logic [`SFDL_NUM_CH-1:0]   w1c;
        logic [`SFDL_CNT_W-1:0]    lim;
        logic [2:0]                ch_sel;
        logic [2:0]                reg_sel;
        logic [1:0]                mode;
        logic                      uv_en;
        logic                      ov_en;
        raw     = '0;
        rise    = '0;
        w1c     = '0;
        lim     = '0;
        mode    = '0;
        uv_en   = 1'b0;
        ov_en   = 1'b0;
        ch_sel  = i_addr[`SFDL_CH_STRIDE_LSB+2:`SFDL_CH_STRIDE_LSB];
        reg_sel = i_addr[`SFDL_CH_STRIDE_LSB-1:0];
        s_d     = s_q;

        // Two-stage synchronisers; only the second stage feeds logic
        s_d.uv_s1 = i_uv_cmp;
        s_d.uv_s2 = s_q.uv_s1;
        s_d.ov_s1 = i_ov_cmp;
        s_d.ov_s2 = s_q.ov_s1;
        s_d.lg_s1 = i_dual_logic_pin;
        s_d.lg_s2 = s_q.lg_s1;

        // Register writes; channel block when the global bit is clear
        if (i_wr) begin
            if (!i_addr[`SFDL_GLOBAL_BIT]) begin
                unique case (reg_sel)
                    `SFDL_REG_UV_TH: begin
                        s_d.uv_th[ch_sel] = i_wdata;
                    end
                    `SFDL_REG_OV_TH: begin
                        s_d.ov_th[ch_sel] = i_wdata;
                    end
                    `SFDL_REG_CFG: begin
                        s_d.cfg[ch_sel] = i_wdata[`SFDL_CFG_W-1:0];
                    end
                    `SFDL_REG_HYST: begin
                        // Upper bits dropped: code tops out at 31
                        s_d.hyst[ch_sel] = i_wdata[`SFDL_HYST_W-1:0];
                    end
                    `SFDL_REG_GLITCH: begin
                        s_d.glitch[ch_sel] = i_wdata[`SFDL_GLITCH_W-1:0];
                    end
                    default: begin
                        // Unused slots ignore writes
                    end
                endcase
            end else if (i_addr == `SFDL_ADDR_STATUS) begin
                w1c = i_wdata;
            end else if (i_addr == `SFDL_ADDR_MASK) begin
                s_d.mask = i_wdata;
            end
        end

        // Read data, valid the cycle after the strobe; unmapped reads zero
        s_d.rdata = `SFDL_RST_ZERO;
        if (i_rd) begin
            if (!i_addr[`SFDL_GLOBAL_BIT]) begin
                unique case (reg_sel)
                    `SFDL_REG_UV_TH: begin
                        s_d.rdata = s_q.uv_th[ch_sel];
                    end
                    `SFDL_REG_OV_TH: begin
                        s_d.rdata = s_q.ov_th[ch_sel];
                    end
                    `SFDL_REG_CFG: begin
                        s_d.rdata = {3'h0, s_q.cfg[ch_sel]};
                    end
                    `SFDL_REG_HYST: begin
                        s_d.rdata = {3'h0, s_q.hyst[ch_sel]};
                    end
                    `SFDL_REG_GLITCH: begin
                        s_d.rdata = {1'b0, s_q.glitch[ch_sel]};
                    end
                    default: begin
                        s_d.rdata = `SFDL_RST_ZERO;
                    end
                endcase
            end else if (i_addr == `SFDL_ADDR_STATUS) begin
                s_d.rdata = s_q.sticky;
            end else if (i_addr == `SFDL_ADDR_MASK) begin
                s_d.rdata = s_q.mask;
            end else if (i_addr == `SFDL_ADDR_LIVE) begin
                s_d.rdata = o_fault;
            end else if (i_addr == `SFDL_ADDR_LOGIC) begin
                s_d.rdata = {4'h0, o_logic_in};
            end
        end

        // Per-channel detection and glitch filtering
        for (int i = 0; i < `SFDL_NUM_CH; i++) begin
            mode  = s_q.cfg[i][`SFDL_CFG_MODE_LSB+1:`SFDL_CFG_MODE_LSB];
            uv_en = (mode == sfdl_pkg::SFDL_MODE_UV) || (mode == sfdl_pkg::SFDL_MODE_WIN);
            ov_en = (mode == sfdl_pkg::SFDL_MODE_OV) || (mode == sfdl_pkg::SFDL_MODE_WIN);

            // Hysteresis only while the filtered fault is active
            if (s_q.filt[i] && !is_logic(i, s_q.cfg[i])) begin
                s_d.uv_code[i] = add_sat(s_q.uv_th[i], s_q.hyst[i]);
                s_d.ov_code[i] = sub_sat(s_q.ov_th[i], s_q.hyst[i]);
            end else begin
                s_d.uv_code[i] = s_q.uv_th[i];
                s_d.ov_code[i] = s_q.ov_th[i];
            end

            // Logic-input use excludes detection on the same channel
            if (is_logic(i, s_q.cfg[i])) begin
                // Index cut to the dual range so detector-only channels stay in bounds
                raw[i] = s_q.lg_s2[($clog2(`SFDL_NUM_DUAL))'(i - `SFDL_FIRST_DUAL)];
            end else begin
                raw[i] = (uv_en && s_q.uv_s2[i]) || (ov_en && s_q.ov_s2[i]);
            end

            // Filter: output follows input held stable for the full timeout
            lim        = timeout_cycles(s_q.glitch[i]);
            s_d.last[i] = raw[i];
            if (raw[i] == s_q.filt[i]) begin
                // Short pulse back to the output level is dropped
                s_d.cnt[i] = '0;
            end else if (lim == '0) begin
                // Zero timeout passes straight through
                s_d.filt[i] = raw[i];
                s_d.cnt[i]  = '0;
            end else if (raw[i] != s_q.last[i]) begin
                // Fresh edge restarts the count
                s_d.cnt[i] = `SFDL_CNT_W'(1);
            end else if (s_q.cnt[i] >= lim) begin
                // Held for the whole timeout: pass the edge
                s_d.filt[i] = raw[i];
                s_d.cnt[i]  = '0;
            end else begin
                s_d.cnt[i] = s_q.cnt[i] + `SFDL_CNT_W'(1);
            end

            // Interrupt events are new detector faults
            rise[i] = s_d.filt[i] && !s_q.filt[i] && !is_logic(i, s_q.cfg[i]);
        end

        // Sticky status: a new event beats a same-cycle clear
        s_d.sticky = (s_q.sticky & ~w1c) | rise;
    end

    // State register with synchronous reset
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Output mapping
    always_comb begin
        o_rdata = s_q.rdata;
        o_irq   = |(s_q.sticky & s_q.mask);
        for (int i = 0; i < `SFDL_NUM_CH; i++) begin
            o_uv_code[i*`SFDL_TH_W +: `SFDL_TH_W] = s_q.uv_code[i];
            o_ov_code[i*`SFDL_TH_W +: `SFDL_TH_W] = s_q.ov_code[i];
            o_range_sel[i*2 +: 2] = legal_range(i,
                s_q.cfg[i][`SFDL_CFG_RANGE_LSB+1:`SFDL_CFG_RANGE_LSB]);
            o_fault[i] = s_q.filt[i] && !is_logic(i, s_q.cfg[i]);
        end
        for (int j = 0; j < `SFDL_NUM_DUAL; j++) begin
            o_dual_is_logic[j] = s_q.cfg[j+`SFDL_FIRST_DUAL][`SFDL_CFG_DIGITAL_BIT];
            o_logic_in[j] = s_q.filt[j+`SFDL_FIRST_DUAL] && o_dual_is_logic[j];
        end
    end

endmodule

/* sim/sfdl_core_chk.sv */
`timescale 1ns/1ps
`include "sfdl_cfg.svh"

module sfdl_core_chk (
    input  wire logic                                 i_core_clk,
    input  wire logic                                 i_rst,
    input  wire logic                                 i_wr,
    input  wire logic                                 i_rd,
    input  wire logic [`SFDL_DATA_W-1:0]              o_rdata,
    input  wire logic [`SFDL_NUM_CH-1:0]              i_uv_cmp,
    input  wire logic [`SFDL_NUM_CH-1:0]              i_ov_cmp,
    input  wire logic [`SFDL_NUM_CH*`SFDL_TH_W-1:0]   o_uv_code,
    input  wire logic [`SFDL_NUM_CH*`SFDL_TH_W-1:0]   o_ov_code,
    input  wire logic [`SFDL_NUM_CH*2-1:0]            o_range_sel,
    input  wire logic [`SFDL_NUM_DUAL-1:0]            o_dual_is_logic,
    input  wire logic [`SFDL_NUM_CH-1:0]              o_fault,
    input  wire logic [`SFDL_NUM_DUAL-1:0]            o_logic_in,
    input  wire logic                                 o_irq
);
    // Single clock domain, so one default clocking and reset cover all checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data seen outside its read slot");
    hv_range_a: assert property (o_range_sel[1] == 1'b1)
        else $error("high voltage channel in a range it lacks");
    pos_range_a: assert property (
        (o_range_sel[3:2] != 2'h3) && (o_range_sel[5:4] != 2'h3) && (o_range_sel[7:6] != 2'h3))
        else $error("positive channel in the top range");
    dual_range_a: assert property (o_range_sel[15:8] == 8'h00)
        else $error("dual channel not in the lowest range");
    dual_excl_a: assert property (((o_fault[7:4] & o_dual_is_logic) == 4'h0)
        && ((o_logic_in & ~o_dual_is_logic) == 4'h0))
        else $error("dual channel acting as detector and logic input");
    // Sync plus filter take at least two cycles, so a fault cannot beat its comparator
    fault_cause_a: assert property ($rose(o_fault[1]) && !$past(i_wr)
        |-> $past(i_uv_cmp[1] | i_ov_cmp[1], 2))
        else $error("fault rose without a comparator cause");
    hyst_uv_a: assert property ($changed(o_uv_code[15:8]) |->
        $past(i_wr) || $past(i_wr, 2) || ($past(o_fault[1]) != $past(o_fault[1], 2)))
        else $error("undervoltage code moved without fault change");
    hyst_ov_a: assert property ($changed(o_ov_code[23:16]) |->
        $past(i_wr) || $past(i_wr, 2) || ($past(o_fault[2]) != $past(o_fault[2], 2)))
        else $error("overvoltage code moved without fault change");
    irq_clear_a: assert property ($fell(o_irq) |-> $past(i_wr))
        else $error("interrupt dropped without a write");
    irq_cause_a: assert property ($rose(o_irq) |-> $past(i_wr) || (o_fault != 8'h00)
        || $past(o_fault != 8'h00))
        else $error("interrupt rose without a fault or write");
endmodule

bind sfdl_core sfdl_core_chk u_chk (
    .i_core_clk      (i_core_clk),
    .i_rst           (i_rst),
    .i_wr            (i_wr),
    .i_rd            (i_rd),
    .o_rdata         (o_rdata),
    .i_uv_cmp        (i_uv_cmp),
    .i_ov_cmp        (i_ov_cmp),
    .o_uv_code       (o_uv_code),
    .o_ov_code       (o_ov_code),
    .o_range_sel     (o_range_sel),
    .o_dual_is_logic (o_dual_is_logic),
    .o_fault         (o_fault),
    .o_logic_in      (o_logic_in),
    .o_irq           (o_irq)
);

/* sim/sfdl_cmp_model.sv */
`timescale 1ns/1ps
`include "sfdl_cfg.svh"

module sfdl_cmp_model (
    input  wire logic [`SFDL_NUM_CH*`SFDL_TH_W-1:0]   i_level,
    input  wire logic [`SFDL_NUM_CH*`SFDL_TH_W-1:0]   i_uv_code,
    input  wire logic [`SFDL_NUM_CH*`SFDL_TH_W-1:0]   i_ov_code,
    output logic      [`SFDL_NUM_CH-1:0]              o_uv_cmp,
    output logic      [`SFDL_NUM_CH-1:0]              o_ov_cmp
);
    // Ideal rails in code units; no offset, so a level equal to a code is in tolerance
    always_comb begin
        for (int ch = 0; ch < `SFDL_NUM_CH; ch++) begin
            o_uv_cmp[ch] = i_level[8*ch +: 8] < i_uv_code[8*ch +: 8];
            o_ov_cmp[ch] = i_level[8*ch +: 8] > i_ov_code[8*ch +: 8];
        end
    end
endmodule

/* sim/sfdl_core_tb.sv */
`timescale 1ns/1ps
`include "sfdl_cfg.svh"

module sfdl_core_tb;
    logic                   i_core_clk = 1'b0;
    logic                   i_rst = 1'b1;
    logic [6:0]             i_addr = 7'h00;
    logic [7:0]             i_wdata = 8'h00;
    logic                   i_wr = 1'b0;
    logic                   i_rd = 1'b0;
    logic [3:0]             i_dual_logic_pin = 4'h0;
    logic [63:0]            level = {8{8'h80}};  // Rail voltage of each channel in code units
    logic [7:0]             o_rdata;
    logic [7:0]             uv_cmp, ov_cmp, o_fault;
    logic [63:0]            o_uv_code, o_ov_code;
    logic [15:0]            o_range_sel;
    logic [3:0]             o_dual_is_logic, o_logic_in;
    logic                   o_irq;
    int                     error_cnt = 0;
    int                     n_compared = 0;

    always #25 i_core_clk = ~i_core_clk;

    sfdl_core u_dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_uv_cmp(uv_cmp),
        .i_ov_cmp(ov_cmp), .i_dual_logic_pin(i_dual_logic_pin), .o_uv_code(o_uv_code),
        .o_ov_code(o_ov_code), .o_range_sel(o_range_sel), .o_dual_is_logic(o_dual_is_logic),
        .o_fault(o_fault), .o_logic_in(o_logic_in), .o_irq(o_irq));
    sfdl_cmp_model u_cmp (.i_level(level), .i_uv_code(o_uv_code), .i_ov_code(o_ov_code),
        .o_uv_cmp(uv_cmp), .o_ov_cmp(ov_cmp));

    task automatic report_and_stop();
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask
    // Bus cycles: strobe one cycle, read data taken in the slot after it
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge i_core_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    task automatic lvl(input int ch, input logic [7:0] v);
        @(posedge i_core_clk);
        level[8*ch +: 8] <= v;
    endtask
    // Bounded wait for a fault level; n is cycles from the last stimulus edge
    task automatic wait_flt(input int ch, input logic v, input int bound, output int n);
        n = 0;
        while (o_fault[ch] !== v && n < bound) begin
            @(posedge i_core_clk);
            #1 n++;
        end
        if (o_fault[ch] !== v) begin
            error_cnt++;
            $display("FAIL at %0t: fault wait ran out", $time);
            report_and_stop();
        end
    endtask
    task automatic hold(input int ch, input logic v, input int cyc, output logic ok);
        ok = 1'b1;
        repeat (cyc) begin
            @(posedge i_core_clk);
            #1 if (o_fault[ch] !== v) ok = 1'b0;
        end
    endtask

    task automatic t_reset();
        logic [7:0] d;
        rd(7'h08, d);
        chk(d, 8'h00, "threshold after reset");
        rd(`SFDL_ADDR_STATUS, d);
        chk(d, 8'h00, "status after reset");
        chk(o_range_sel, 16'h0002, "range after reset");
        chk({o_fault, o_irq}, 9'h000, "fault after reset");
    endtask
    task automatic t_range();
        for (int ch = 0; ch < 8; ch++) wr(7'(ch * 8 + 2), 8'h0C);
        chk(o_range_sel, 16'h00AB, "top range request");
        for (int ch = 0; ch < 8; ch++) wr(7'(ch * 8 + 2), 8'h04);
        chk(o_range_sel, 16'h0056, "second range request");
        for (int ch = 0; ch < 8; ch++) wr(7'(ch * 8 + 2), 8'h00);
    endtask
    // Undervoltage on channel 1 with the largest hysteresis code
    task automatic t_uv();
        int n;
        logic ok;
        logic [7:0] d;
        wr(7'h08, 8'h80);
        rd(7'h08, d);
        chk(d, 8'h80, "uv threshold readback");
        wr(7'h0B, 8'h1F);
        wr(7'h0A, 8'h01);
        lvl(1, 8'h70);
        wait_flt(1, 1'b1, 10, n);
        chk(n, 3, "unfiltered latency");
        repeat (2) @(posedge i_core_clk);
        #1 chk(o_uv_code[15:8], 8'h9F, "raised uv code");
        lvl(1, 8'h90);
        hold(1, 1'b1, 10, ok);
        chk(ok, 1'b1, "uv fault inside hysteresis");
        lvl(1, 8'hA0);
        wait_flt(1, 1'b0, 10, n);
        repeat (2) @(posedge i_core_clk);
        #1 chk(o_uv_code[15:8], 8'h80, "uv code back");
    endtask
    task automatic t_ov();
        int n;
        logic ok;
        wr(7'h11, 8'h40);
        wr(7'h13, 8'h10);
        lvl(2, 8'h30);
        wr(7'h12, 8'h02);
        lvl(2, 8'h50);
        wait_flt(2, 1'b1, 10, n);
        repeat (2) @(posedge i_core_clk);
        #1 chk(o_ov_code[23:16], 8'h30, "lowered ov code");
        lvl(2, 8'h38);
        hold(2, 1'b1, 10, ok);
        chk(ok, 1'b1, "ov fault inside hysteresis");
        lvl(2, 8'h20);
        wait_flt(2, 1'b0, 10, n);
    endtask
    // Window on channel 3, then the same rail with undervoltage only
    task automatic t_window();
        logic [7:0] lv[4] = '{8'h30, 8'h80, 8'hD0, 8'h80};
        int n;
        logic ok;
        wr(7'h18, 8'h40);
        wr(7'h19, 8'hC0);
        // Let the old over-threshold comparator state drain before arming
        repeat (4) @(posedge i_core_clk);
        wr(7'h1A, 8'h03);
        for (int i = 0; i < 4; i++) begin
            lvl(3, lv[i]);
            wait_flt(3, ~i[0], 10, n);
        end
        wr(7'h1A, 8'h01);
        lvl(3, 8'hD0);
        hold(3, 1'b0, 10, ok);
        chk(ok, 1'b1, "high rail in uv mode");
    endtask
    task automatic t_glitch();
        int n;
        logic ok;
        wr(7'h0C, 8'h01);
        lvl(1, 8'h70);
        repeat (10) @(posedge i_core_clk);
        lvl(1, 8'hA0);
        hold(1, 1'b0, 40, ok);
        chk(ok, 1'b1, "short pulse passed");
        lvl(1, 8'h70);
        repeat (15) @(posedge i_core_clk);
        lvl(1, 8'hA0);
        lvl(1, 8'h70);
        repeat (15) @(posedge i_core_clk);
        lvl(1, 8'hA0);
        hold(1, 1'b0, 40, ok);
        chk(ok, 1'b1, "filter did not restart");
        lvl(1, 8'h70);
        wait_flt(1, 1'b1, 40, n);
        chk(n >= 20 && n <= 24, 1'b1, "one microsecond lag");
        lvl(1, 8'hA0);
        wait_flt(1, 1'b0, 40, n);
        wr(7'h0C, 8'h7F);
        lvl(1, 8'h70);
        wait_flt(1, 1'b1, 2100, n);
        chk(n >= 2000 && n <= 2004, 1'b1, "timeout capped at 100us");
        lvl(1, 8'hA0);
        wait_flt(1, 1'b0, 2100, n);
        wr(7'h0C, 8'h00);
    endtask
    task automatic t_irq();
        logic [7:0] d;
        int n;
        rd(`SFDL_ADDR_STATUS, d);
        chk(d, 8'h0E, "sticky fault events");
        chk(o_irq, 1'b0, "masked interrupt");
        wr(`SFDL_ADDR_MASK, 8'h02);
        chk(o_irq, 1'b1, "unmasked interrupt");
        wr(`SFDL_ADDR_STATUS, 8'h0E);
        chk(o_irq, 1'b0, "cleared interrupt");
        lvl(1, 8'h70);
        wait_flt(1, 1'b1, 10, n);
        repeat (2) @(posedge i_core_clk);
        #1 chk(o_irq, 1'b1, "fault event interrupt");
        rd(`SFDL_ADDR_LIVE, d);
        chk(d, 8'h02, "live fault view");
        lvl(1, 8'hA0);
        wait_flt(1, 1'b0, 10, n);
        wr(`SFDL_ADDR_STATUS, 8'h02);
        chk(o_irq, 1'b0, "interrupt after clear");
        wr(7'h7F, 8'hFF);
        rd(7'h7F, d);
        chk(d, 8'h00, "unmapped read");
        rd(`SFDL_ADDR_MASK, d);
        chk(d, 8'h02, "mask readback");
    endtask
    // Channel 4 as logic input: its detector must stay silent
    task automatic t_logic();
        logic [7:0] d;
        logic ok;
        int n;
        wr(7'h20, 8'h80);
        wr(7'h22, 8'h11);
        lvl(4, 8'h00);
        i_dual_logic_pin <= 4'h1;
        hold(4, 1'b0, 10, ok);
        chk({ok, o_dual_is_logic, o_logic_in}, 9'h111, "logic input path");
        rd(`SFDL_ADDR_LOGIC, d);
        chk(d, 8'h01, "logic input readback");
        // Pin low first, so the detector fault below is its own and not left over
        @(posedge i_core_clk);
        i_dual_logic_pin <= 4'h0;
        hold(4, 1'b0, 5, ok);
        chk({ok, o_logic_in}, 5'h10, "logic input released");
        wr(7'h22, 8'h01);
        chk({o_dual_is_logic, o_logic_in}, 8'h00, "back to detector");
        wait_flt(4, 1'b1, 10, n);
    endtask

    initial begin
        repeat (2) @(posedge i_core_clk);
        i_rst <= 1'b0;
        t_reset();
        t_range();
        t_uv();
        t_ov();
        t_window();
        t_glitch();
        t_irq();
        t_logic();
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge i_core_clk);
        error_cnt++;
        $display("FAIL at %0t: run did not finish", $time);
        report_and_stop();
    end
endmodule
